// ### dv/dss_contacts.sv
// contact switch and panel key model for the selector bench
// assumes the bench sets the wanted levels just after a clock edge
`timescale 1ns/1ps
module dss_contacts (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic [15:0] want,
    output logic      [15:0] pins,
    output logic             quiet
);
    logic [1:0] wait_q;
    initial pins = 16'h0000;
    initial wait_q = 2'h0;
    assign quiet = (pins === want);
    // a slow contact lags three cycles before it closes or opens
    always @(posedge clk)
    begin
        if (pins === want)
            wait_q <= 2'h0;
        else if (slow && wait_q != 2'h3)
            wait_q <= wait_q + 2'h1;
        else
            pins <= want;
    end
endmodule

// ### dv/dss_top_tb.sv
// self-checking bench of the speed and direction selector
// assumes dss_top, the contact model and a 100 MHz clock
`timescale 1ns/1ps
`include "dss_consts.svh"
module dss_top_tb;
    typedef struct {logic rd; logic [31:0] v;} dss_note_s;
    localparam logic [15:0] FW = 16'h0100;
    localparam logic [15:0] RV = 16'h0200;
    localparam logic [15:0] SF = 16'h0400;
    localparam logic [15:0] RK = 16'h0800;
    localparam logic [15:0] FK = 16'h1000;
    localparam logic [15:0] VK = 16'h2000;
    localparam logic [15:0] SK = 16'h4000;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        rd_dp, pin_ck, a4v, slow, quiet, run, rev, inch, sre;
    logic        rdy_s;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, lfsr;
    logic [15:0] want, pins, a4f, a2f, freq, iramp, rref, x, y, inf;
    logic [31:0] rst3 [3] = '{32'h1770, 32'h0BB8, 32'h03E8};
    dss_note_s   notes[$];
    int          mismatches, comparisons;

    dss_top #(.NT(8), .INIT_GROUP(1)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .term_in(pins[7:0]),
        .forward_start_input(pins[8]), .reverse_start_input(pins[9]),
        .second_function_select(pins[10]), .panel_run_key(pins[11]),
        .panel_fwd_key(pins[12]), .panel_rev_key(pins[13]),
        .panel_stop_key(pins[14]), .analog4_valid(a4v),
        .analog4_freq(a4f), .analog2_freq(a2f), .motor_run(run),
        .motor_reverse(rev), .inching_active(inch),
        .second_ramp_enable(sre), .freq_command(freq),
        .inching_ramp_time(iramp), .ramp_reference_frequency(rref)
    );
    dss_contacts i_sw (
        .clk(hclk), .slow(slow), .want(want), .pins(pins), .quiet(quiet)
    );

    always #5 hclk = ~hclk;

    // ready as it stood in the cycle before each rising edge
    always @(negedge hclk)
        rdy_s = hreadyout;

    function automatic logic [15:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return 16'(lfsr % 32'd59001);
    endfunction

    task automatic final_report;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic cmp(input logic k, input logic [31:0] got);
        dss_note_s n;
        n = notes.pop_front();
        comparisons++;
        // the frequency of a stopped motor is not judged
        if (!k && !n.v[19])
            got[15:0] = n.v[15:0];
        if (n.rd !== k || n.v !== got)
        begin
            mismatches++;
            $display("BAD %0t: got %h want %h", $time, got, n.v);
        end
    endtask

    task automatic xfer(input logic w, input logic [5:0] ix,
                        input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, ix, 2'h0};
        do @(posedge hclk); while (rdy_s !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp <= ~w;
        do @(posedge hclk); while (rdy_s !== 1'b1);
        rd_dp <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] ix, input logic [31:0] d);
        xfer(1'b1, ix, d);
    endtask

    task automatic rd(input logic [5:0] ix, input logic [31:0] e);
        notes.push_back('{1'b1, e});
        xfer(1'b0, ix, 32'h0);
    endtask

    // expected: {run, reverse, inching, second ramp, frequency}
    task automatic pin(input logic [15:0] w, input logic [19:0] e);
        want <= w;
        @(posedge hclk);
        do @(posedge hclk); while (quiet !== 1'b1);
        // two sync stages, the one-push latch and the output register
        repeat (4) @(posedge hclk);
        notes.push_back('{1'b0, {12'h0, e}});
        pin_ck <= 1'b1;
        @(posedge hclk);
        pin_ck <= 1'b0;
    endtask

    // outputs are judged mid-cycle, where they have settled
    always @(negedge hclk)
    begin
        if (rd_dp && hreadyout === 1'b1)
            cmp(1'b1, hrdata);
        if (pin_ck)
            cmp(1'b0, {12'h0, run, rev, inch, sre, freq});
    end

    initial
    begin
        repeat (5000) @(posedge hclk);
        mismatches++;
        final_report();
    end

    initial
    begin
        {hclk, hresetn, hsel, hwrite, rd_dp, pin_ck, a4v, slow} = '0;
        {haddr, hwdata, htrans, want, a4f, a2f} = '0;
        hsize = 3'h2;
        lfsr = 32'h0F3EECC4;
        mismatches = 0;
        comparisons = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(`DSS_IX_CTRL, 32'h0);
        rd(`DSS_IX_INCH_FREQ, 32'h01F4);
        rd(`DSS_IX_INCH_RAMP, 32'h0005);
        rd(`DSS_IX_RAMP_REF, 32'h1770);
        for (int i = 0; i < 15; i++)
            rd(`DSS_IX_PRESET + 6'(i), i < 3 ? rst3[i] : 32'h270F);
        wr(6'h13, 32'h1234);
        rd(6'h13, 32'h0);
        wr(`DSS_IX_INCH_FREQ, 32'hE679);
        rd(`DSS_IX_INCH_FREQ, 32'h01F4);
        wr(`DSS_IX_INCH_FREQ, 32'hE678);
        rd(`DSS_IX_INCH_FREQ, 32'hE678);
        wr(`DSS_IX_INCH_RAMP, 32'h8CA0);
        wr(`DSS_IX_INCH_RAMP, 32'h8CA1);
        rd(`DSS_IX_INCH_RAMP, 32'h8CA0);
        inf = rnd();
        // inching target drawn at random from 0 up to DSS_FREQ_MAX
        wr(`DSS_IX_INCH_FREQ, {16'h0, inf});
        x = rnd();
        y = rnd();
        a4f <= x;
        a2f <= y;
        a4v <= 1'b1;
        pin(FW, {4'h8, x});
        a4v <= 1'b0;
        pin(FW, {4'h8, y});
        pin(FW | 16'h0004, {4'h8, 16'h1770});
        pin(FW | 16'h0002, {4'h8, 16'h0BB8});
        pin(FW | 16'h0001, {4'h8, 16'h03E8});
        pin(FW | 16'h0006, {4'h8, 16'h0BB8});
        pin(FW | 16'h0007, {4'h8, 16'h03E8});
        x = rnd();
        wr(`DSS_IX_PRESET + 6'h3, {16'h0, x});
        pin(FW | 16'h0003, {4'h8, x});
        pin(FW | SF | 16'h0001, {4'h9, 16'h03E8});
        pin(FW | RV | 16'h0001, {4'h0, 16'h0});
        wr(`DSS_IX_CTRL, 32'h1);
        pin(RV | 16'h0001, {4'h0, 16'h0});
        pin(FW | 16'h0001, {4'h8, 16'h03E8});
        wr(`DSS_IX_CTRL, 32'h2);
        pin(FW | 16'h0001, {4'h0, 16'h0});
        pin(RV | 16'h0001, {4'hC, 16'h03E8});
        pin(16'h0001, {4'h0, 16'h0});
        wr(`DSS_IX_CMD, 32'h1);
        pin(16'h0001, {4'h0, 16'h0});
        wr(`DSS_IX_CTRL, 32'h3);
        rd(`DSS_IX_CTRL, 32'h2);
        wr(`DSS_IX_CTRL, 32'h0);
        pin(16'h0001, {4'h8, 16'h03E8});
        wr(`DSS_IX_CMD, 32'h2);
        pin(16'h0001, {4'hC, 16'h03E8});
        wr(`DSS_IX_CMD, 32'h0);
        slow <= 1'b1;
        wr(`DSS_IX_TMAP + 6'h3, {26'h0, `DSS_FN_INCH1});
        pin(FW | SF | 16'h0009, {4'hA, inf});
        pin(RV | 16'h0008, {4'hE, inf});
        pin(16'h0008, {4'h0, 16'h0});
        wr(`DSS_IX_CTRL, 32'h0C);
        pin(FW | 16'h0009, {4'h8, 16'h03E8});
        wr(`DSS_IX_CTRL, 32'h0);
        wr(`DSS_IX_TMAP + 6'h5, {26'h0, `DSS_FN_INCH2});
        pin(FW | 16'h0020, {4'hA, inf});
        wr(`DSS_IX_CMD, 32'h4);
        pin(FW, {4'hA, inf});
        wr(`DSS_IX_CMD, 32'h0);
        slow <= 1'b0;
        wr(`DSS_IX_TMAP, {26'h0, `DSS_FN_HIGH});
        pin(FW | 16'h0001, {4'h8, 16'h1770});
        wr(`DSS_IX_TMAP, {26'h0, `DSS_FN_LOW});
        wr(`DSS_IX_TMAP + 6'h4, {26'h0, `DSS_FN_EXT});
        pin(FW | 16'h0010, {4'h8, 16'h03E8});
        x = rnd();
        y = rnd();
        wr(`DSS_IX_PRESET + 6'h7, {16'h0, x});
        wr(`DSS_IX_PRESET_LAST, {16'h0, y});
        pin(FW | 16'h0010, {4'h8, x});
        pin(FW | 16'h0017, {4'h8, y});
        pin(16'h0000, {4'h0, 16'h0});
        wr(`DSS_IX_CTRL, 32'h20);
        pin(RK, {4'hA, inf});
        pin(VK, {4'hE, inf});
        pin(16'h0000, {4'h0, 16'h0});
        wr(`DSS_IX_CTRL, 32'h10);
        pin(VK, {4'hE, inf});
        pin(16'h0000, {4'hE, inf});
        pin(SK, {4'h0, 16'h0});
        pin(FK, {4'hA, inf});
        pin(SK, {4'h0, 16'h0});
        pin(RK, {4'hA, inf});
        pin(SK, {4'h0, 16'h0});
        wr(`DSS_IX_CTRL, 32'h11);
        pin(VK, {4'h0, 16'h0});
        pin(16'h0000, {4'h0, 16'h0});
        repeat (2) @(posedge hclk);
        final_report();
    end
endmodule

// ### rtl/dss_consts.svh
// register indices, field positions, reset values and function codes
// assumes word-aligned register access (byte address = index * 4)
`ifndef DSS_CONSTS_SVH
`define DSS_CONSTS_SVH
`define DSS_IX_CTRL        6'h00
`define DSS_IX_INCH_FREQ   6'h01
`define DSS_IX_INCH_RAMP   6'h02
`define DSS_IX_RAMP_REF    6'h03
`define DSS_IX_PRESET      6'h04
`define DSS_IX_PRESET_LAST 6'h12
`define DSS_IX_TMAP        6'h14
`define DSS_IX_CMD         6'h1C
`define DSS_IX_STATUS      6'h1D
`define DSS_IX_FREQ        6'h1E
`define DSS_CTRL_INH_LSB   0
`define DSS_CTRL_OPM_LSB   2
`define DSS_CTRL_PINCH     5
`define DSS_CMD_FWD        0
`define DSS_CMD_REV        1
`define DSS_CMD_INCH2      2
`define DSS_INH_REV        2'h1
`define DSS_INH_FWD        2'h2
`define DSS_OPM_NO_INCH    3'h3
`define DSS_OPM_PUSH       3'h4
`define DSS_FREQ_MAX       16'hE678
`define DSS_RAMP_MAX       16'h8CA0
`define DSS_NOT_SEL        16'h270F
`define DSS_INCH_FREQ_RST  16'h01F4
`define DSS_INCH_RAMP_RST  16'h0005
`define DSS_G1_HIGH_RST    16'h1770
`define DSS_G2_HIGH_RST    16'h1388
`define DSS_MID_RST        16'h0BB8
`define DSS_LOW_RST        16'h03E8
`define DSS_SLOT_HIGH      4'h0
`define DSS_SLOT_MID       4'h1
`define DSS_SLOT_LOW       4'h2
`define DSS_SLOT_SPEED8    4'h7
`define DSS_FN_LOW         6'h00
`define DSS_FN_MID         6'h01
`define DSS_FN_HIGH        6'h02
`define DSS_FN_INCH1       6'h05
`define DSS_FN_EXT         6'h08
`define DSS_FN_INCH2       6'h1E
`define DSS_FN_NONE        6'h3F
`define DSS_INCH1_TERMS    7
`endif

// ### rtl/dss_pkg.sv
// shared types of the speed and direction selector
// assumes nothing beyond a SystemVerilog compiler
package dss_pkg;
    typedef enum logic [1:0] {PANEL_STOP, PANEL_FWD, PANEL_REV} dss_panel_e;
    typedef logic [15:0] dss_freq_t;
endpackage

// ### rtl/dss_top.sv
// speed command and rotation direction selector with ahb-lite registers
// assumes one 100 MHz clock; contacts and panel keys arrive unsynchronised
`timescale 1ns/1ps
`include "dss_consts.svh"

module dss_top #(
    parameter int NT         = 8,
    parameter int INIT_GROUP = 1
) (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic      [31:0]   hrdata,
    output logic               hreadyout,
    output logic               hresp,
    input  wire logic [NT-1:0] term_in,
    input  wire logic          forward_start_input,
    input  wire logic          reverse_start_input,
    input  wire logic          second_function_select,
    input  wire logic          panel_run_key,
    input  wire logic          panel_fwd_key,
    input  wire logic          panel_rev_key,
    input  wire logic          panel_stop_key,
    input  wire logic          analog4_valid,
    input  wire logic [15:0]   analog4_freq,
    input  wire logic [15:0]   analog2_freq,
    output logic               motor_run,
    output logic               motor_reverse,
    output logic               inching_active,
    output logic               second_ramp_enable,
    output logic      [15:0]   freq_command,
    output logic      [15:0]   inching_ramp_time,
    output logic      [15:0]   ramp_reference_frequency
);
    localparam int PW = NT + 7;
    localparam int PF = NT;
    localparam int PR = NT + 1;
    localparam int PS = NT + 2;
    localparam int KR = NT + 3;
    localparam int KF = NT + 4;
    localparam int KV = NT + 5;
    localparam int KS = NT + 6;

    typedef struct packed {
        logic [PW-1:0]          sync1;
        logic [PW-1:0]          sync2;
        logic [PW-1:0]          prev;
        logic [1:0]             inhibit;
        logic [2:0]             opmode;
        logic                   panel_inch;
        dss_pkg::dss_freq_t     inch_freq;
        logic [15:0]            inch_ramp;
        dss_pkg::dss_freq_t     ramp_ref;
        logic [14:0][15:0]      preset;
        logic [NT-1:0][5:0]     tmap;
        logic [2:0]             cmd;
        dss_pkg::dss_panel_e    panel;
        logic                   acc_wr;
        logic                   acc_rd;
        logic [5:0]             aidx;
        logic [31:0]            rdata;
        logic                   rdy;
        logic                   run;
        logic                   rev;
        logic                   inch;
        logic                   second;
        dss_pkg::dss_freq_t     freq;
        logic [15:0]            ramp;
    } dss_state_s;

    function automatic dss_state_s rst_val();
        dss_state_s r;
        r = '0;
        r.inch_freq = `DSS_INCH_FREQ_RST;
        r.inch_ramp = `DSS_INCH_RAMP_RST;
        r.ramp_ref = (INIT_GROUP == 2) ? `DSS_G2_HIGH_RST
                                       : `DSS_G1_HIGH_RST;
        for (int i = 0; i < 15; i++)
            r.preset[i] = `DSS_NOT_SEL;
        r.preset[`DSS_SLOT_HIGH] = r.ramp_ref;
        r.preset[`DSS_SLOT_MID] = `DSS_MID_RST;
        r.preset[`DSS_SLOT_LOW] = `DSS_LOW_RST;
        for (int i = 0; i < NT; i++)
            r.tmap[i] = `DSS_FN_NONE;
        r.tmap[0] = `DSS_FN_LOW;
        r.tmap[1] = `DSS_FN_MID;
        r.tmap[2] = `DSS_FN_HIGH;
        r.panel = dss_pkg::PANEL_STOP;
        r.rdy = 1'b1;
        return r;
    endfunction

    localparam dss_state_s RST_STATE = rst_val();

    dss_state_s s_q;
    dss_state_s s_d;

    logic [NT-1:0] hit_low;
    logic [NT-1:0] hit_mid;
    logic [NT-1:0] hit_high;
    logic [NT-1:0] hit_ext;
    logic [NT-1:0] hit_inch1;
    logic [NT-1:0] hit_inch2;

    // function decode of each assignable terminal
    for (genvar i = 0; i < NT; i++)
    begin : g_term
        assign hit_low[i]  = s_q.sync2[i] && s_q.tmap[i] == `DSS_FN_LOW;
        assign hit_mid[i]  = s_q.sync2[i] && s_q.tmap[i] == `DSS_FN_MID;
        assign hit_high[i] = s_q.sync2[i] && s_q.tmap[i] == `DSS_FN_HIGH;
        assign hit_ext[i]  = s_q.sync2[i] && s_q.tmap[i] == `DSS_FN_EXT;
        assign hit_inch1[i] = (i < `DSS_INCH1_TERMS) && s_q.sync2[i]
                              && s_q.tmap[i] == `DSS_FN_INCH1;
        assign hit_inch2[i] = s_q.sync2[i]
                              && s_q.tmap[i] == `DSS_FN_INCH2;
    end

    logic [3:0]  code;
    logic [3:0]  slot;
    logic [15:0] lower_val;
    logic [15:0] preset_val;
    logic        preset_on;

    always_comb
    begin
        code = {|hit_ext, |hit_high, |hit_mid, |hit_low};
        preset_on = |code;
        // lower-speed select wins when a combination is unset
        if (code[0])
            lower_val = s_q.preset[`DSS_SLOT_LOW];
        else if (code[1])
            lower_val = s_q.preset[`DSS_SLOT_MID];
        else if (code[2])
            lower_val = s_q.preset[`DSS_SLOT_HIGH];
        else
            lower_val = s_q.preset[`DSS_SLOT_LOW];
        if (code[3])
            slot = code - 4'h1;
        else
        begin
            case (code)
                4'h3:    slot = 4'h3;
                4'h5:    slot = 4'h4;
                4'h6:    slot = 4'h5;
                4'h7:    slot = 4'h6;
                default: slot = 4'hF;
            endcase
        end
        if (slot == 4'hF || s_q.preset[slot] == `DSS_NOT_SEL)
            preset_val = lower_val;
        else
            preset_val = s_q.preset[slot];
    end

    logic inch_ok;
    logic inch_sel;
    logic held_f;
    logic held_r;
    logic fwd_all;
    logic rev_all;
    logic fwd_ok;
    logic rev_ok;
    logic run_d;
    logic [PW-1:0] rise;
    logic [5:0]  pidx;
    logic [5:0]  tidx;
    logic [15:0] wv;

    always_comb
    begin
        s_d = s_q;
        rise = s_q.sync2 & ~s_q.prev;
        s_d.sync1 = {panel_stop_key, panel_rev_key, panel_fwd_key,
                     panel_run_key, second_function_select,
                     reverse_start_input, forward_start_input, term_in};
        s_d.sync2 = s_q.sync1;
        s_d.prev = s_q.sync2;

        inch_ok = s_q.opmode != `DSS_OPM_NO_INCH;
        inch_sel = inch_ok && (|hit_inch1 || |hit_inch2
                   || s_q.cmd[`DSS_CMD_INCH2]);
        // held-key panel inching, outside one-push mode
        held_f = inch_ok && s_q.panel_inch && s_q.opmode != `DSS_OPM_PUSH
                 && (s_q.sync2[KR] || s_q.sync2[KF]);
        held_r = inch_ok && s_q.panel_inch && s_q.opmode != `DSS_OPM_PUSH
                 && s_q.sync2[KV];

        // one-push panel inching in mode 4
        case (s_q.panel)
            dss_pkg::PANEL_STOP:
            begin
                if ((rise[KR] || rise[KF])
                    && s_q.inhibit != `DSS_INH_FWD)
                    s_d.panel = dss_pkg::PANEL_FWD;
                else if (rise[KV] && s_q.inhibit != `DSS_INH_REV)
                    s_d.panel = dss_pkg::PANEL_REV;
            end
            dss_pkg::PANEL_FWD,
            dss_pkg::PANEL_REV:
            begin
                if (s_q.sync2[KS])
                    s_d.panel = dss_pkg::PANEL_STOP;
            end
            default: s_d.panel = dss_pkg::PANEL_STOP;
        endcase
        if (s_q.opmode != `DSS_OPM_PUSH)
            s_d.panel = dss_pkg::PANEL_STOP;

        fwd_all = s_q.sync2[PF] || s_q.cmd[`DSS_CMD_FWD] || held_f
                  || s_q.panel == dss_pkg::PANEL_FWD;
        rev_all = s_q.sync2[PR] || s_q.cmd[`DSS_CMD_REV] || held_r
                  || s_q.panel == dss_pkg::PANEL_REV;
        fwd_ok = fwd_all && s_q.inhibit != `DSS_INH_FWD;
        rev_ok = rev_all && s_q.inhibit != `DSS_INH_REV;
        run_d = fwd_ok ^ rev_ok;
        s_d.run = run_d;
        s_d.rev = rev_ok && !fwd_ok;
        s_d.inch = run_d && (inch_sel || held_f || held_r
                   || s_q.panel != dss_pkg::PANEL_STOP);
        s_d.second = s_q.sync2[PS] && !s_d.inch;
        s_d.ramp = s_q.inch_ramp;
        if (s_d.inch)
            s_d.freq = s_q.inch_freq;
        else if (preset_on)
            s_d.freq = preset_val;
        else if (analog4_valid)
            s_d.freq = analog4_freq;
        else
            s_d.freq = analog2_freq;

        // ahb-lite slave: writes zero wait, reads one wait state
        wv = hwdata[15:0];
        pidx = s_q.aidx - `DSS_IX_PRESET;
        tidx = s_q.aidx - `DSS_IX_TMAP;
        s_d.acc_wr = 1'b0;
        s_d.acc_rd = 1'b0;
        s_d.rdy = 1'b1;
        if (hsel && htrans[1] && hready)
        begin
            s_d.aidx = haddr[7:2];
            s_d.acc_wr = hwrite;
            s_d.acc_rd = !hwrite;
            s_d.rdy = hwrite;
        end
        if (s_q.acc_wr)
        begin
            if (s_q.aidx == `DSS_IX_CTRL)
            begin
                if (hwdata[`DSS_CTRL_INH_LSB +: 2] != 2'h3)
                    s_d.inhibit = hwdata[`DSS_CTRL_INH_LSB +: 2];
                s_d.opmode = hwdata[`DSS_CTRL_OPM_LSB +: 3];
                s_d.panel_inch = hwdata[`DSS_CTRL_PINCH];
            end
            else if (s_q.aidx == `DSS_IX_INCH_FREQ && wv <= `DSS_FREQ_MAX)
                s_d.inch_freq = wv;
            else if (s_q.aidx == `DSS_IX_INCH_RAMP && wv <= `DSS_RAMP_MAX)
                s_d.inch_ramp = wv;
            else if (s_q.aidx == `DSS_IX_RAMP_REF && wv <= `DSS_FREQ_MAX)
                s_d.ramp_ref = wv;
            else if (s_q.aidx >= `DSS_IX_PRESET
                     && s_q.aidx <= `DSS_IX_PRESET_LAST)
            begin
                if (wv <= `DSS_FREQ_MAX || (pidx > 6'h2
                    && wv == `DSS_NOT_SEL))
                    s_d.preset[pidx[3:0]] = wv;
            end
            else if (s_q.aidx >= `DSS_IX_TMAP
                     && tidx < 6'(NT))
                s_d.tmap[tidx[3:0]] = hwdata[5:0];
            else if (s_q.aidx == `DSS_IX_CMD)
                s_d.cmd = hwdata[2:0];
        end
        if (s_q.acc_rd)
        begin
            s_d.rdata = '0;
            if (s_q.aidx == `DSS_IX_CTRL)
                s_d.rdata[5:0] = {s_q.panel_inch, s_q.opmode, s_q.inhibit};
            else if (s_q.aidx == `DSS_IX_INCH_FREQ)
                s_d.rdata[15:0] = s_q.inch_freq;
            else if (s_q.aidx == `DSS_IX_INCH_RAMP)
                s_d.rdata[15:0] = s_q.inch_ramp;
            else if (s_q.aidx == `DSS_IX_RAMP_REF)
                s_d.rdata[15:0] = s_q.ramp_ref;
            else if (s_q.aidx >= `DSS_IX_PRESET
                     && s_q.aidx <= `DSS_IX_PRESET_LAST)
                s_d.rdata[15:0] = s_q.preset[pidx[3:0]];
            else if (s_q.aidx >= `DSS_IX_TMAP && tidx < 6'(NT))
                s_d.rdata[5:0] = s_q.tmap[tidx[3:0]];
            else if (s_q.aidx == `DSS_IX_CMD)
                s_d.rdata[2:0] = s_q.cmd;
            else if (s_q.aidx == `DSS_IX_STATUS)
                s_d.rdata[3:0] = {s_q.second, s_q.inch, s_q.rev, s_q.run};
            else if (s_q.aidx == `DSS_IX_FREQ)
                s_d.rdata[15:0] = s_q.freq;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_q <= RST_STATE;
        else
            s_q <= s_d;
    end

    assign hrdata = s_q.rdata;
    assign hreadyout = s_q.rdy;
    assign hresp = 1'b0;
    assign motor_run = s_q.run;
    assign motor_reverse = s_q.rev;
    assign inching_active = s_q.inch;
    assign second_ramp_enable = s_q.second;
    assign freq_command = s_q.freq;
    assign inching_ramp_time = s_q.ramp;
    assign ramp_reference_frequency = s_q.ramp_ref;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    no_reverse_a: assert property (
        (s_q.run && s_q.rev) |-> $past(s_q.inhibit) != `DSS_INH_REV)
        else $error("reverse run while reverse inhibited");
    no_forward_a: assert property (
        (s_q.run && !s_q.rev) |-> $past(s_q.inhibit) != `DSS_INH_FWD)
        else $error("forward run while forward inhibited");
    inch_freq_a: assert property (
        s_q.inch |-> s_q.freq == $past(s_q.inch_freq))
        else $error("inching frequency not applied");
    inch_ramp_a: assert property (
        s_q.inch |-> s_q.ramp == $past(s_q.inch_ramp))
        else $error("inching ramp time not applied");
    mode_three_a: assert property (
        s_q.inch |-> $past(s_q.opmode) != `DSS_OPM_NO_INCH)
        else $error("inching in mode 3");
    second_off_a: assert property (
        s_q.inch |-> !s_q.second)
        else $error("second ramp during inching");
    low_wins_a: assert property (
        (code == 4'h6 && s_q.preset[5] == `DSS_NOT_SEL)
        |-> preset_val == s_q.preset[`DSS_SLOT_MID])
        else $error("high plus middle did not pick middle");
    ext_only_a: assert property (
        (code == 4'h8 && s_q.preset[`DSS_SLOT_SPEED8] == `DSS_NOT_SEL)
        |-> preset_val == s_q.preset[`DSS_SLOT_LOW])
        else $error("extension alone did not pick low preset");
    push_stop_a: assert property (
        (s_q.panel != dss_pkg::PANEL_STOP && s_q.sync2[KS])
        |=> s_q.panel == dss_pkg::PANEL_STOP)
        else $error("stop key did not end one-push inching");
    read_wait_a: assert property (
        (hsel && htrans[1] && hready && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    inch_run_c: cover property (s_q.inch && s_q.run);
    reverse_run_c: cover property (s_q.run && s_q.rev);
    push_mode_c: cover property (s_q.panel == dss_pkg::PANEL_FWD);
    preset_c: cover property (preset_on && slot != 4'hF && !s_q.inch);
endmodule
